// >>> hw/ocpwm_core.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_core (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic cpu_idle_i,
  input wire logic module_disable_gate_i,
  input wire logic channel_present_i,
  input wire logic [15:0] timebase_a_i,
  input wire logic [15:0] timebase_b_i,
  input wire logic fault_i,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic compare_output_pin_o,
  output logic irq_o
);
  logic fault_s1_q, fault_s2_q;
  logic active;
  logic [15:0] ctrl_q;
  logic [15:0] cmpa_q, cmpb_q;
  localparam int unsigned ST_W_L = ocpwm_pkg::ST_W;
  logic [ST_W_L-1:0] stat_q, mask_q;
  logic [3:0] aw_q;
  logic aw_v_q, w_v_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic pin_q, pulse_done_q, fault_lock_q;
  logic [2:0] mode_prev_q;
  logic run, cmp_a, cmp_b, flt_ev;
  logic [15:0] tb;
  ocpwm_pkg::ocpwm_mode_t mode;

  ocpwm_gate u_gate (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .disable_req_i(module_disable_gate_i),
    .present_i(channel_present_i),
    .active_o(active)
  );

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Only the four aligned register words decode
  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == ocpwm_pkg::CTRL_OFS) | (a == ocpwm_pkg::CMPA_OFS) | (a == ocpwm_pkg::CMPB_OFS)
                  | (a == ocpwm_pkg::STAT_OFS);
  endfunction

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_s1_q <= 1'b0;
      fault_s2_q <= 1'b0;
    end else if (clk_en_i) begin
      fault_s1_q <= fault_i;
      fault_s2_q <= fault_s1_q;
    end
  end

  assign mode = ocpwm_pkg::ocpwm_mode_t'(ctrl_q[ocpwm_pkg::MODE_LO +: 3]);
  // Channel advances only when ungated and not idle-stopped
  assign run = clk_en_i & active & ~(cpu_idle_i & ctrl_q[ocpwm_pkg::IDLE_BIT]);
  assign tb = ctrl_q[ocpwm_pkg::TSEL_BIT] ? timebase_b_i : timebase_a_i;
  assign cmp_a = (tb == cmpa_q);
  assign cmp_b = (tb == cmpb_q);
  assign flt_ev = (mode == ocpwm_pkg::OCPWM_PWM_FLT) & fault_s2_q;

  // Write channel: capture address and data independently
  wire wr_go = aw_v_q & w_v_q & ~s_axi_bvalid;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      aw_q <= 4'h0;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ocpwm_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      s_axi_awready <= ~aw_v_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_v_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_v_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_v_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_q) ? ocpwm_pkg::RESP_OKAY : ocpwm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_ok = wr_go & active;
  wire wr_ctrl = wr_ok & (aw_q == ocpwm_pkg::CTRL_OFS);
  wire wr_stat = wr_ok & (aw_q == ocpwm_pkg::STAT_OFS);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= ocpwm_pkg::CTRL_RESET;
      cmpa_q <= 16'h0000;
      cmpb_q <= 16'h0000;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        ctrl_q <= (merge16(ctrl_q, wd_q, ws_q) & ocpwm_pkg::CTRL_WMASK)
                  | (ctrl_q & ~ocpwm_pkg::CTRL_WMASK);
      end
      if (wr_ok & (aw_q == ocpwm_pkg::CMPA_OFS)) begin
        cmpa_q <= merge16(cmpa_q, wd_q, ws_q);
      end
      if (wr_ok & (aw_q == ocpwm_pkg::CMPB_OFS)) begin
        cmpb_q <= merge16(cmpb_q, wd_q, ws_q);
      end
      if (run) begin
        if (flt_ev) begin
          ctrl_q[ocpwm_pkg::FLT_BIT] <= 1'b1;
        end else if (mode != ocpwm_pkg::OCPWM_PWM_FLT) begin
          ctrl_q[ocpwm_pkg::FLT_BIT] <= 1'b0;
        end
      end
    end
  end

  // Output pin sequencer
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_q <= 1'b0;
      pulse_done_q <= 1'b0;
      fault_lock_q <= 1'b0;
      mode_prev_q <= 3'h0;
    end else if (run) begin
      mode_prev_q <= mode;
      if (mode != ocpwm_mode_t_cast(mode_prev_q)) begin
        pulse_done_q <= 1'b0;
        fault_lock_q <= 1'b0;
        pin_q <= (mode == ocpwm_pkg::OCPWM_SET_LO);
      end else begin
        case (mode)
          ocpwm_pkg::OCPWM_OFF: pin_q <= 1'b0;
          ocpwm_pkg::OCPWM_SET_HI: if (cmp_a) pin_q <= 1'b1;
          ocpwm_pkg::OCPWM_SET_LO: if (cmp_a) pin_q <= 1'b0;
          ocpwm_pkg::OCPWM_TOGGLE: if (cmp_a) pin_q <= ~pin_q;
          ocpwm_pkg::OCPWM_ONE_PULSE: begin
            if (cmp_a & ~pulse_done_q) begin
              pin_q <= 1'b1;
            end else if (cmp_b & pin_q) begin
              pin_q <= 1'b0;
              pulse_done_q <= 1'b1;
            end
          end
          ocpwm_pkg::OCPWM_CONT_PULSE: begin
            if (cmp_a) begin
              pin_q <= 1'b1;
            end else if (cmp_b) begin
              pin_q <= 1'b0;
            end
          end
          ocpwm_pkg::OCPWM_PWM, ocpwm_pkg::OCPWM_PWM_FLT: begin
            if (flt_ev | fault_lock_q) begin
              fault_lock_q <= 1'b1;
              pin_q <= 1'b0;
            end else if (tb == 16'h0000) begin
              pin_q <= (cmpa_q != 16'h0000);
            end else if (cmp_a) begin
              pin_q <= 1'b0;
            end
          end
          default: pin_q <= 1'b0;
        endcase
      end
    end
  end

  function automatic ocpwm_pkg::ocpwm_mode_t ocpwm_mode_t_cast(input logic [2:0] v);
    ocpwm_mode_t_cast = ocpwm_pkg::ocpwm_mode_t'(v);
  endfunction

  logic compare_output_pin_o_d;
  assign compare_output_pin_o_d = pin_q & active;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      compare_output_pin_o <= 1'b0;
    end else if (clk_en_i) begin
      compare_output_pin_o <= compare_output_pin_o_d;
    end
  end

  // Sticky events, write one to clear; set wins
  wire [ST_W_L-1:0] ev = {~active, run & flt_ev, run & cmp_a & (mode != ocpwm_pkg::OCPWM_OFF)};
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      stat_q <= ev | (stat_q & ~((wr_stat & ws_q[0]) ? wd_q[ST_W_L-1:0] : {ST_W_L{1'b0}}));
      if (wr_stat & ws_q[2]) begin
        mask_q <= wd_q[ocpwm_pkg::STAT_MASK_SHIFT +: ST_W_L];
      end
      irq_o <= |(stat_q & mask_q);
    end
  end

  // Read channel; gated channel returns zero for CTRL, CMPA and CMPB; STAT still reads mask and status
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ocpwm_pkg::RESP_OKAY;
    end else if (clk_en_i) begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ocpwm_pkg::RESP_OKAY;
        case (s_axi_araddr)
          ocpwm_pkg::CTRL_OFS: s_axi_rdata <= active ? {16'h0000, ctrl_q} : 32'h0000_0000;
          ocpwm_pkg::CMPA_OFS: s_axi_rdata <= active ? {16'h0000, cmpa_q} : 32'h0000_0000;
          ocpwm_pkg::CMPB_OFS: s_axi_rdata <= active ? {16'h0000, cmpb_q} : 32'h0000_0000;
          ocpwm_pkg::STAT_OFS: s_axi_rdata <= {13'h0, mask_q, 13'h0, stat_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ocpwm_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_idle_halt: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i & cpu_idle_i & ctrl_q[ocpwm_pkg::IDLE_BIT]) |=> $stable(pin_q))
    else $error("pin moved while idle-stopped");
  a_flt_only_pwm: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode != ocpwm_pkg::OCPWM_PWM_FLT) |=> !ctrl_q[ocpwm_pkg::FLT_BIT])
    else $error("fault flag set outside fault pwm");
  a_flt_sets: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & flt_ev) |=> ctrl_q[ocpwm_pkg::FLT_BIT])
    else $error("fault not flagged");
  a_flt_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i & mode == ocpwm_pkg::OCPWM_PWM_FLT & ctrl_q[ocpwm_pkg::FLT_BIT]) |=> ctrl_q[ocpwm_pkg::FLT_BIT])
    else $error("fault flag cleared in fault pwm");
  a_fault_sticky: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & flt_ev) |=> stat_q[ocpwm_pkg::ST_FLT])
    else $error("fault event not latched");
  a_fault_pin_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & flt_ev & mode_prev_q == mode) |=> ##1 !compare_output_pin_o)
    else $error("pin active after fault");
  a_toggle_cmp: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_TOGGLE & mode_prev_q == mode & cmp_a) |=> pin_q != $past(pin_q))
    else $error("toggle missed");
  a_set_hi: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_SET_HI & mode_prev_q == mode & cmp_a) |=> pin_q)
    else $error("force high missed");
  a_set_lo: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_SET_LO & mode_prev_q == mode & cmp_a) |=> !pin_q)
    else $error("force low missed");
  a_init_hi: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_SET_LO & mode_prev_q != mode) |=> pin_q)
    else $error("pin not initialised high");
  a_init_lo: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode != ocpwm_pkg::OCPWM_SET_LO & mode_prev_q != mode) |=> !pin_q)
    else $error("pin not initialised low");
  a_one_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_ONE_PULSE & mode_prev_q == mode & pulse_done_q) |=> !pin_q)
    else $error("second single pulse");
  a_cont_rise: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_CONT_PULSE & mode_prev_q == mode & cmp_a) |=> pin_q)
    else $error("continuous pulse missed");
  a_pwm_period: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_PWM & mode_prev_q == mode & tb == 16'h0000 & cmpa_q != 16'h0000) |=> pin_q)
    else $error("pwm period start missed");
  a_off_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (run & mode == ocpwm_pkg::OCPWM_OFF) |=> !pin_q)
    else $error("pin high while off");
  a_gate_delay: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i & module_disable_gate_i) |=> !active)
    else $error("gate not applied after one cycle");
  a_gate_release: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i & !module_disable_gate_i) |=> (active | !channel_present_i))
    else $error("gate not released after one cycle");
  a_gate_pin_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i & !active) |=> !compare_output_pin_o)
    else $error("pin driven while gated");
  a_gate_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (clk_en_i & !active) |=> $stable(cmpa_q))
    else $error("gated write took effect");
  c_toggle: cover property (@(posedge core_clk_i) run & mode == ocpwm_pkg::OCPWM_TOGGLE & cmp_a);
  c_fault: cover property (@(posedge core_clk_i) run & flt_ev);
  c_gate: cover property (@(posedge core_clk_i) !active ##1 active);
  c_one_pulse: cover property (@(posedge core_clk_i) run & mode == ocpwm_pkg::OCPWM_ONE_PULSE & pulse_done_q);
  c_idle_hold: cover property (@(posedge core_clk_i) clk_en_i & cpu_idle_i & ctrl_q[ocpwm_pkg::IDLE_BIT]);
endmodule
`default_nettype wire

// >>> hw/ocpwm_gate.sv
`timescale 1ns/10ps
`default_nettype none
// Delays the disable request by one instruction cycle
module ocpwm_gate (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic disable_req_i,
  input wire logic present_i,
  output logic active_o
);
  logic dis_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dis_q <= 1'b0;
    end else if (clk_en_i) begin
      dis_q <= disable_req_i;
    end
  end
  assign active_o = present_i & ~dis_q;
endmodule
`default_nettype wire

// >>> hw/ocpwm_pkg.sv
package ocpwm_pkg;
  localparam int unsigned ADDR_W = 4;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CMPA_OFS = 4'h4;
  localparam logic [3:0] CMPB_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;
  // Control field positions
  localparam int unsigned IDLE_BIT = 13;
  localparam int unsigned FLT_BIT = 4;
  localparam int unsigned TSEL_BIT = 3;
  localparam int unsigned MODE_LO = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h200F;
  // Status / mask bits
  localparam int unsigned ST_CMP = 0;
  localparam int unsigned ST_FLT = 1;
  localparam int unsigned ST_DIS = 2;
  localparam int unsigned ST_W = 3;
  localparam int unsigned STAT_MASK_SHIFT = 16;
  // Mode field codes
  typedef enum logic [2:0] {
    OCPWM_OFF = 3'h0,
    OCPWM_SET_HI = 3'h1,
    OCPWM_SET_LO = 3'h2,
    OCPWM_TOGGLE = 3'h3,
    OCPWM_ONE_PULSE = 3'h4,
    OCPWM_CONT_PULSE = 3'h5,
    OCPWM_PWM = 3'h6,
    OCPWM_PWM_FLT = 3'h7
  } ocpwm_mode_t;
  // Gate delay: one instruction cycle, in core clocks
  localparam int unsigned GATE_DLY = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> tb/ocpwm_load.sv
`timescale 1ns/10ps
`default_nettype none
// Load on the compare pin: counts high cycles and rising edges
module ocpwm_load (
  input wire logic core_clk_i,
  input wire logic clr_i,
  input wire logic pin_i,
  input wire logic flt_req_i,
  output logic fault_o,
  output logic [15:0] high_o,
  output logic [15:0] rise_o
);
  logic last_q;
  assign fault_o = flt_req_i;
  always_ff @(posedge core_clk_i) begin
    last_q <= pin_i;
    if (clr_i) begin
      high_o <= 16'h0;
      rise_o <= 16'h0;
    end else begin
      high_o <= high_o + {15'h0, pin_i};
      rise_o <= rise_o + {15'h0, pin_i & ~last_q};
    end
  end
endmodule
`default_nettype wire

// >>> tb/output_compare_pwm_channel_tb.sv
`timescale 1ns/10ps
`default_nettype none
module output_compare_pwm_channel_tb;
  localparam logic [3:0] CT = ocpwm_pkg::CTRL_OFS;
  localparam logic [3:0] CA = ocpwm_pkg::CMPA_OFS;
  localparam logic [3:0] CB = ocpwm_pkg::CMPB_OFS;
  localparam logic [3:0] ST = ocpwm_pkg::STAT_OFS;
  localparam logic [1:0] OK = ocpwm_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ocpwm_pkg::RESP_SLVERR;
  logic clk = 1'b0, rst = 1'b1, idle = 1'b0, gate = 1'b0, flt = 1'b0, clr = 1'b0, pres = 1'b1;
  logic [15:0] tba = 16'h0, tbb = 16'h0, hi, ri;
  logic [3:0] aw = 4'h0, ar = 4'h0;
  logic [31:0] wd = 32'h0, rd;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wr, bv, arr, rv, pin, irq, fault;
  logic [1:0] br, rr;
  int fails = 0, compares = 0;
  always #50 clk = ~clk;
  // Timebase a wraps every 16 clocks, b every 64
  always @(posedge clk) begin
    tba <= (tba == 16'h000F) ? 16'h0 : tba + 16'h1;
    tbb <= (tbb == 16'h003F) ? 16'h0 : tbb + 16'h1;
  end
  ocpwm_core i_ocpwm_core (.core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1), .cpu_idle_i(idle),
    .module_disable_gate_i(gate), .channel_present_i(pres), .timebase_a_i(tba), .timebase_b_i(tbb),
    .fault_i(fault), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .compare_output_pin_o(pin), .irq_o(irq));
  ocpwm_load i_ocpwm_load (.core_clk_i(clk), .clr_i(clr), .pin_i(pin), .flt_req_i(flt),
    .fault_o(fault), .high_o(hi), .rise_o(ri));
  task automatic give_verdict();
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 40);
    bry <= 1'b0;
    if (n >= 40) fails++;
    chk_rsp(br, er);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 40);
    rry <= 1'b0;
    if (n >= 40) fails++;
    if (er == OK) chk(rd, exp);
    chk_rsp(rr, er);
  endtask
  // High count is skipped when 16'hFFFF: frozen pin level is arbitrary
  task automatic meas(input int settle, input logic [15:0] eh, input logic [15:0] er);
    cyc(settle);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(65);
    if (eh !== 16'hFFFF) chk({16'h0, hi}, {16'h0, eh});
    chk({16'h0, ri}, {16'h0, er});
  endtask
  initial begin
    cyc(4);
    rst <= 1'b0;
    rd_reg(CT, 32'h0, OK);
    rd_reg(4'h2, 32'h0, ER);
    wr_reg(4'h2, 32'h0, ER);
    wr_reg(CT, 32'h0000FFFF, OK);
    rd_reg(CT, {16'h0, ocpwm_pkg::CTRL_WMASK}, OK);
    wr_reg(CA, 32'h12340028, OK);
    rd_reg(CA, 32'h00000028, OK);
    wr_reg(CT, 32'h2, OK);
    meas(32, 16'h0040, 16'h0);
    wr_reg(CT, 32'h1, OK);
    meas(32, 16'h0, 16'h0);
    wr_reg(CT, 32'h9, OK);
    meas(64, 16'h0040, 16'h0);
    wr_reg(CA, 32'h5, OK);
    wr_reg(CT, 32'h3, OK);
    meas(32, 16'h0020, 16'h2);
    wr_reg(CB, 32'h9, OK);
    @(posedge clk iff tba == 16'h0008);
    wr_reg(CT, 32'h4, OK);
    meas(0, 16'h0004, 16'h1);
    wr_reg(CT, 32'h5, OK);
    meas(32, 16'h0010, 16'h4);
    wr_reg(CT, 32'h6, OK);
    flt <= 1'b1;
    meas(32, 16'h0014, 16'h4);
    rd_reg(CT, 32'h6, OK);
    wr_reg(CT, 32'h7, OK);
    meas(32, 16'h0, 16'h0);
    wr_reg(CT, 32'h7, OK);
    rd_reg(CT, 32'h17, OK);
    rd_reg(ST, 32'h3, OK);
    chk({31'h0, irq}, 32'h0);
    wr_reg(ST, 32'h00020000, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    flt <= 1'b0;
    cyc(4);
    wr_reg(ST, 32'h00020002, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd_reg(ST, 32'h00020001, OK);
    wr_reg(CT, 32'h0, OK);
    rd_reg(CT, 32'h0, OK);
    meas(32, 16'h0, 16'h0);
    wr_reg(CT, 32'h2003, OK);
    idle <= 1'b1;
    meas(8, 16'hFFFF, 16'h0);
    wr_reg(CT, 32'h0003, OK);
    meas(32, 16'h0020, 16'h2);
    idle <= 1'b0;
    gate <= 1'b1;
    meas(4, 16'h0000, 16'h0);
    rd_reg(CT, 32'h0, OK);
    wr_reg(CT, 32'h1, OK);
    gate <= 1'b0;
    rd_reg(CT, 32'h3, OK);
    meas(32, 16'h0020, 16'h2);
    pres <= 1'b0;
    rd_reg(CT, 32'h0, OK);
    pres <= 1'b1;
    rd_reg(CT, 32'h3, OK);
    give_verdict();
  end
  initial begin
    cyc(20000);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
